// file: verilog/acsf_top.v
// axis command and status flags with a classic wishbone register slave
//
// Notes on behaviour
// - servo bit rise enables, fall disables servo
// - error clear bit rise clears pending error
// - stop bit rises start decel or emergency stop
// - clutch engaged status and transition busy flag
// - speed and torque done on target or limit
// - speed running flag high during speed mode
// - torque running flag high during torque mode
// - limit switches and soft limits shown as levels
// - each probe has a triggered flag
// - tracking error and parameter effective flags
// - origin, positive, negative, index shown as levels
`timescale 1ns/1ns
`default_nettype none
`include "acsf_map.vh"
module acsf_top #(
   parameter ADR_W = 8
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [ADR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg irq,
   input wire origin_pin,
   input wire positive_pin,
   input wire negative_pin,
   input wire index_pin,
   input wire start_limit_pin,
   input wire pos_limit_pin,
   input wire neg_limit_pin,
   input wire probe1_pin,
   input wire probe2_pin,
   input wire drive_fault,
   input wire clutch_engage_done,
   input wire clutch_release_done,
   input wire speed_reached,
   input wire speed_at_limit,
   input wire torque_reached,
   input wire torque_at_limit,
   input wire tracking_error,
   input wire sync_params_applied,
   input wire fwd_soft_limit,
   input wire rev_soft_limit,
   output reg axis_servo_on,
   output reg axis_fault_clear,
   output reg axis_decel_stop,
   output reg axis_emerg_stop,
   output reg axis_clutch_engage,
   output reg axis_speed_run,
   output reg axis_torque_run
);
   // software registers
   reg [`ACSF_CMD_W-1:0] cmd;
   reg [`ACSF_MODE_W-1:0] mode;
   reg [`ACSF_EV_W-1:0] evt;
   reg [`ACSF_EV_W-1:0] evt_mask;
   // hardware flags
   reg error_pending;
   reg emerg_active;
   reg clutch_engaged_status;
   reg clutch_transition_active;
   reg speed_done;
   reg torque_done;
   reg probe1_hit;
   reg probe2_hit;
   reg track_flag;
   reg next_error_pending;
   reg next_emerg_active;
   reg next_clutch_engaged;
   reg next_clutch_busy;
   reg next_speed_run;
   reg next_torque_run;
   reg next_speed_done;
   reg next_torque_done;
   reg next_probe1_hit;
   reg next_probe2_hit;
   reg next_track_flag;
   reg next_servo_on;
   reg [`ACSF_EV_W-1:0] ev_now;
   reg [31:0] next_rdata;
   reg [`ACSF_ST_W-1:0] stat;

   wire [`ACSF_IN_W-1:0] pins_raw;
   wire [`ACSF_IN_W-1:0] pins;
   wire [`ACSF_IN_W-1:0] pin_rise;
   wire [`ACSF_CMD_W-1:0] cmd_rise;
   wire [`ACSF_CMD_W-1:0] cmd_fall;
   wire bus_req;
   wire wr_lo;
   wire stop_any;

   // register hit for a given offset, used by every decode below
   function hit;
      input [ADR_W-1:0] adr;
      input [7:0] ofs;
      begin
         hit = (adr[7:0] == ofs);
      end
   endfunction

   assign pins_raw = {rev_soft_limit, fwd_soft_limit, sync_params_applied, tracking_error,
                      torque_at_limit, torque_reached, speed_at_limit, speed_reached,
                      clutch_release_done, clutch_engage_done, drive_fault, probe2_pin,
                      probe1_pin, neg_limit_pin, pos_limit_pin, start_limit_pin,
                      index_pin, negative_pin, positive_pin, origin_pin};

   // every outside input is synchronised before use
   acsf_sync #(
      .WIDTH(`ACSF_IN_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // command edges against the previous scan
   acsf_edge #(
      .WIDTH(`ACSF_CMD_W)
   ) u_cmd_edge (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .level_in(cmd),
      .rise(cmd_rise),
      .fall(cmd_fall)
   );

   // rising edges on probe pins
   acsf_edge #(
      .WIDTH(`ACSF_IN_W)
   ) u_pin_edge (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .level_in(pins),
      .rise(pin_rise),
      .fall()
   );

   // a request is taken in the cycle before ack, so it acts exactly once
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // all writable fields live in byte lane 0
   assign wr_lo = bus_req & wb_we_i & wb_sel_i[0];
   assign stop_any = cmd_rise[`ACSF_CMD_DSTOP] | cmd_rise[`ACSF_CMD_ESTOP];

   // next values of the axis flags; a set always wins over a clear
   always @* begin
      next_servo_on = axis_servo_on;
      if (cmd_rise[`ACSF_CMD_SERVO]) begin
         next_servo_on = 1'b1;
      end else if (cmd_fall[`ACSF_CMD_SERVO]) begin
         next_servo_on = 1'b0;
      end
      next_error_pending = pins[`ACSF_IN_FAULT] |
                           (error_pending & ~cmd_rise[`ACSF_CMD_ERRCLR]);
      next_track_flag = pins[`ACSF_IN_TRACK_ERR] |
                        (track_flag & ~cmd_rise[`ACSF_CMD_ERRCLR]);
      // emergency state holds until the error is cleared
      next_emerg_active = cmd_rise[`ACSF_CMD_ESTOP] |
                          (emerg_active & ~cmd_rise[`ACSF_CMD_ERRCLR]);
      // clutch completes only on the drive's own done signals
      next_clutch_engaged = clutch_engaged_status;
      if (axis_clutch_engage & pins[`ACSF_IN_ENG_DONE]) begin
         next_clutch_engaged = 1'b1;
      end else if (~axis_clutch_engage & pins[`ACSF_IN_REL_DONE]) begin
         next_clutch_engaged = 1'b0;
      end
      next_clutch_busy = cmd[`ACSF_CMD_SYNC] ^ next_clutch_engaged;
      // modes run only with servo on and no stop in force; speed has priority
      next_speed_run = mode[`ACSF_MODE_SPEED] & next_servo_on & ~stop_any &
                       ~next_emerg_active;
      next_torque_run = mode[`ACSF_MODE_TORQUE] & ~mode[`ACSF_MODE_SPEED] &
                        next_servo_on & ~stop_any & ~next_emerg_active;
      // done flags restart with each new run
      next_speed_done = speed_done;
      if (next_speed_run & ~axis_speed_run) begin
         next_speed_done = 1'b0;
      end
      if (axis_speed_run & (pins[`ACSF_IN_SPD_REACH] | pins[`ACSF_IN_SPD_LIM])) begin
         next_speed_done = 1'b1;
      end
      next_torque_done = torque_done;
      if (next_torque_run & ~axis_torque_run) begin
         next_torque_done = 1'b0;
      end
      if (axis_torque_run & (pins[`ACSF_IN_TRQ_REACH] | pins[`ACSF_IN_TRQ_LIM])) begin
         next_torque_done = 1'b1;
      end
      // probe latches arm by enable, rearm by the reset command
      next_probe1_hit = (pin_rise[`ACSF_IN_PROBE1] & mode[`ACSF_MODE_PRB1EN]) |
                        (probe1_hit & ~cmd_rise[`ACSF_CMD_PRB1RST]);
      next_probe2_hit = (pin_rise[`ACSF_IN_PROBE2] & mode[`ACSF_MODE_PRB2EN]) |
                        (probe2_hit & ~cmd_rise[`ACSF_CMD_PRB2RST]);
      // events are the rising moments of the flags; sync done is the fall of the clutch busy flag
      ev_now = {`ACSF_EV_W{1'b0}};
      ev_now[`ACSF_EV_SPD_DONE] = next_speed_done & ~speed_done;
      ev_now[`ACSF_EV_TRQ_DONE] = next_torque_done & ~torque_done;
      ev_now[`ACSF_EV_TRACK_ERR] = next_track_flag & ~track_flag;
      ev_now[`ACSF_EV_PRB1] = next_probe1_hit & ~probe1_hit;
      ev_now[`ACSF_EV_PRB2] = next_probe2_hit & ~probe2_hit;
      ev_now[`ACSF_EV_SYNC_DONE] = ~next_clutch_busy & clutch_transition_active;
      ev_now[`ACSF_EV_ERROR] = next_error_pending & ~error_pending;
   end

   // status word; bits above the last field read as zero
   always @* begin
      stat = {`ACSF_ST_W{1'b0}};
      stat[`ACSF_ST_SERVO_ON] = axis_servo_on;
      stat[`ACSF_ST_ERROR] = error_pending;
      stat[`ACSF_ST_EMERG] = emerg_active;
      stat[`ACSF_ST_SYNC_BUSY] = clutch_transition_active;
      stat[`ACSF_ST_SYNC_ON] = clutch_engaged_status;
      stat[`ACSF_ST_SPD_RUN] = axis_speed_run;
      stat[`ACSF_ST_SPD_DONE] = speed_done;
      stat[`ACSF_ST_TRQ_RUN] = axis_torque_run;
      stat[`ACSF_ST_TRQ_DONE] = torque_done;
      stat[`ACSF_ST_FWD_SOFT] = pins[`ACSF_IN_FWD_SOFT];
      stat[`ACSF_ST_REV_SOFT] = pins[`ACSF_IN_REV_SOFT];
      stat[`ACSF_ST_START_LIM] = pins[`ACSF_IN_START_LIM];
      stat[`ACSF_ST_POS_LIM] = pins[`ACSF_IN_POS_LIM];
      stat[`ACSF_ST_NEG_LIM] = pins[`ACSF_IN_NEG_LIM];
      stat[`ACSF_ST_PRB1] = probe1_hit;
      stat[`ACSF_ST_PRB2] = probe2_hit;
      stat[`ACSF_ST_PARAM_OK] = pins[`ACSF_IN_PARAM_OK];
      stat[`ACSF_ST_TRACK_ERR] = track_flag;
      stat[`ACSF_ST_ORIGIN] = pins[`ACSF_IN_ORIGIN];
      stat[`ACSF_ST_POS] = pins[`ACSF_IN_POS];
      stat[`ACSF_ST_NEG] = pins[`ACSF_IN_NEG];
      stat[`ACSF_ST_INDEX] = pins[`ACSF_IN_INDEX];
   end

   // read mux; unmapped offsets answer zero
   always @* begin
      next_rdata = 32'h00000000;
      if (hit(wb_adr_i, `ACSF_CMD_OFS)) begin
         next_rdata[`ACSF_CMD_W-1:0] = cmd;
      end else if (hit(wb_adr_i, `ACSF_STAT_OFS)) begin
         next_rdata[`ACSF_ST_W-1:0] = stat;
      end else if (hit(wb_adr_i, `ACSF_EVT_OFS)) begin
         next_rdata[`ACSF_EV_W-1:0] = evt;
      end else if (hit(wb_adr_i, `ACSF_MASK_OFS)) begin
         next_rdata[`ACSF_EV_W-1:0] = evt_mask;
      end else if (hit(wb_adr_i, `ACSF_MODE_OFS)) begin
         next_rdata[`ACSF_MODE_W-1:0] = mode;
      end
   end

   // bus slave: one wait state, ack for every address
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? next_rdata : 32'h00000000;
      end
   end

   // software registers; only defined bits are stored
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd <= `ACSF_CMD_RST;
         mode <= `ACSF_MODE_RST;
         evt_mask <= `ACSF_MASK_RST;
         evt <= `ACSF_EVT_RST;
      end else begin
         if (wr_lo & hit(wb_adr_i, `ACSF_CMD_OFS)) begin
            cmd <= wb_dat_i[`ACSF_CMD_W-1:0];
         end
         if (wr_lo & hit(wb_adr_i, `ACSF_MASK_OFS)) begin
            evt_mask <= wb_dat_i[`ACSF_EV_W-1:0];
         end
         // a stop cancels the requested run so it does not restart by itself
         if (stop_any) begin
            mode <= mode & ~({{(`ACSF_MODE_W-2){1'b0}}, 2'b11});
         end else if (wr_lo & hit(wb_adr_i, `ACSF_MODE_OFS)) begin
            mode <= wb_dat_i[`ACSF_MODE_W-1:0];
         end
         // write one to clear; a new event in the same cycle wins
         if (wr_lo & hit(wb_adr_i, `ACSF_EVT_OFS)) begin
            evt <= (evt & ~wb_dat_i[`ACSF_EV_W-1:0]) | ev_now;
         end else begin
            evt <= evt | ev_now;
         end
      end
   end

   // axis flags and drive outputs, all registered
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         axis_servo_on <= 1'b0;
         axis_fault_clear <= 1'b0;
         axis_decel_stop <= 1'b0;
         axis_emerg_stop <= 1'b0;
         axis_clutch_engage <= 1'b0;
         axis_speed_run <= 1'b0;
         axis_torque_run <= 1'b0;
         error_pending <= 1'b0;
         emerg_active <= 1'b0;
         clutch_engaged_status <= 1'b0;
         clutch_transition_active <= 1'b0;
         speed_done <= 1'b0;
         torque_done <= 1'b0;
         probe1_hit <= 1'b0;
         probe2_hit <= 1'b0;
         track_flag <= 1'b0;
         irq <= 1'b0;
      end else begin
         axis_servo_on <= next_servo_on;
         axis_fault_clear <= cmd_rise[`ACSF_CMD_ERRCLR];
         axis_decel_stop <= cmd_rise[`ACSF_CMD_DSTOP];
         axis_emerg_stop <= cmd_rise[`ACSF_CMD_ESTOP];
         axis_clutch_engage <= cmd[`ACSF_CMD_SYNC];
         axis_speed_run <= next_speed_run;
         axis_torque_run <= next_torque_run;
         error_pending <= next_error_pending;
         emerg_active <= next_emerg_active;
         clutch_engaged_status <= next_clutch_engaged;
         clutch_transition_active <= next_clutch_busy;
         speed_done <= next_speed_done;
         torque_done <= next_torque_done;
         probe1_hit <= next_probe1_hit;
         probe2_hit <= next_probe2_hit;
         track_flag <= next_track_flag;
         // one cycle behind the sticky bits, keeps the output a plain flop
         irq <= |(evt & evt_mask);
      end
   end
endmodule
`default_nettype wire

// file: verilog/acsf_map.vh
// register offsets, field positions and reset values for the axis flag block
`ifndef ACSF_MAP_VH
`define ACSF_MAP_VH

// register byte offsets
`define ACSF_CMD_OFS 8'h00
`define ACSF_STAT_OFS 8'h04
`define ACSF_EVT_OFS 8'h08
`define ACSF_MASK_OFS 8'h0C
`define ACSF_MODE_OFS 8'h10

// command register bit positions
`define ACSF_CMD_SERVO 0
`define ACSF_CMD_ERRCLR 1
`define ACSF_CMD_DSTOP 2
`define ACSF_CMD_ESTOP 3
`define ACSF_CMD_SYNC 4
`define ACSF_CMD_PRB1RST 5
`define ACSF_CMD_PRB2RST 6
`define ACSF_CMD_W 7

// mode register bit positions
`define ACSF_MODE_SPEED 0
`define ACSF_MODE_TORQUE 1
`define ACSF_MODE_PRB1EN 2
`define ACSF_MODE_PRB2EN 3
`define ACSF_MODE_W 4

// synchronised input vector positions
`define ACSF_IN_ORIGIN 0
`define ACSF_IN_POS 1
`define ACSF_IN_NEG 2
`define ACSF_IN_INDEX 3
`define ACSF_IN_START_LIM 4
`define ACSF_IN_POS_LIM 5
`define ACSF_IN_NEG_LIM 6
`define ACSF_IN_PROBE1 7
`define ACSF_IN_PROBE2 8
`define ACSF_IN_FAULT 9
`define ACSF_IN_ENG_DONE 10
`define ACSF_IN_REL_DONE 11
`define ACSF_IN_SPD_REACH 12
`define ACSF_IN_SPD_LIM 13
`define ACSF_IN_TRQ_REACH 14
`define ACSF_IN_TRQ_LIM 15
`define ACSF_IN_TRACK_ERR 16
`define ACSF_IN_PARAM_OK 17
`define ACSF_IN_FWD_SOFT 18
`define ACSF_IN_REV_SOFT 19
`define ACSF_IN_W 20

// status register bit positions
`define ACSF_ST_SERVO_ON 0
`define ACSF_ST_ERROR 1
`define ACSF_ST_EMERG 2
`define ACSF_ST_SYNC_BUSY 3
`define ACSF_ST_SYNC_ON 4
`define ACSF_ST_SPD_RUN 5
`define ACSF_ST_SPD_DONE 6
`define ACSF_ST_TRQ_RUN 7
`define ACSF_ST_TRQ_DONE 8
`define ACSF_ST_FWD_SOFT 9
`define ACSF_ST_REV_SOFT 10
`define ACSF_ST_START_LIM 11
`define ACSF_ST_POS_LIM 12
`define ACSF_ST_NEG_LIM 13
`define ACSF_ST_PRB1 14
`define ACSF_ST_PRB2 15
`define ACSF_ST_PARAM_OK 16
`define ACSF_ST_TRACK_ERR 17
`define ACSF_ST_ORIGIN 18
`define ACSF_ST_POS 19
`define ACSF_ST_NEG 20
`define ACSF_ST_INDEX 21
`define ACSF_ST_W 22

// interrupt event bit positions
`define ACSF_EV_SPD_DONE 0
`define ACSF_EV_TRQ_DONE 1
`define ACSF_EV_TRACK_ERR 2
`define ACSF_EV_PRB1 3
`define ACSF_EV_PRB2 4
`define ACSF_EV_SYNC_DONE 5
`define ACSF_EV_ERROR 6
`define ACSF_EV_W 7

// reset values
`define ACSF_CMD_RST 7'h00
`define ACSF_MODE_RST 4'h0
`define ACSF_MASK_RST 7'h00
`define ACSF_EVT_RST 7'h00

`endif

// file: verilog/acsf_sync.v
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ns
`default_nettype none
module acsf_sync #(
   parameter WIDTH = 20
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// file: verilog/acsf_edge.v
// edge finder comparing each bit with its value one scan earlier
`timescale 1ns/1ns
`default_nettype none
module acsf_edge #(
   parameter WIDTH = 7
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire [WIDTH-1:0] level_in,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);
   reg [WIDTH-1:0] prev;

   // previous scan value; each edge lasts exactly one cycle
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev <= {WIDTH{1'b0}};
      end else begin
         prev <= level_in;
      end
   end

   assign rise = level_in & ~prev;
   assign fall = ~level_in & prev;
endmodule
`default_nettype wire

// file: dv/acsf_top_asserts.sv
// concurrent checks on the ports of the axis flag block
`timescale 1ns/1ns
`default_nettype none
module acsf_top_asserts #(
   parameter ADR_W = 8
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irq,
   input wire logic axis_servo_on,
   input wire logic axis_fault_clear,
   input wire logic axis_decel_stop,
   input wire logic axis_emerg_stop,
   input wire logic axis_clutch_engage,
   input wire logic axis_speed_run,
   input wire logic axis_torque_run
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // a command write is taken while the slave has not answered yet
   wire cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
      && wb_adr_i[7:0] == 8'h00;
   wire cmd_ack = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:0] == 8'h00;
   wire pulse = axis_fault_clear || axis_decel_stop || axis_emerg_stop;
   chk_ack_next: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_servo_follow: assert property (cmd_wr |-> ##2 (axis_servo_on == $past(wb_dat_i[0], 2)))
      else $error("servo output does not follow command bit");
   chk_clutch_req: assert property (cmd_wr |-> ##2 (axis_clutch_engage == $past(wb_dat_i[4], 2)))
      else $error("clutch request does not follow command bit");
   chk_clear_cause: assert property (axis_fault_clear |-> $past(cmd_ack) && $past(wb_dat_i[1]))
      else $error("error clear pulse without command");
   chk_decel_cause: assert property (axis_decel_stop |-> $past(cmd_ack) && $past(wb_dat_i[2]))
      else $error("decel pulse without command");
   chk_emerg_cause: assert property (axis_emerg_stop |-> $past(cmd_ack) && $past(wb_dat_i[3]))
      else $error("emergency pulse without command");
   chk_pulse_once: assert property (pulse |=> !pulse)
      else $error("command pulse repeated");
   chk_stop_halts: assert property (pulse && !axis_fault_clear |=> !axis_speed_run && !axis_torque_run)
      else $error("run output survives a stop");
   chk_mode_excl: assert property (!(axis_speed_run && axis_torque_run))
      else $error("speed and torque run together");
   chk_read_rsvd: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:22] == 10'h000)
      else $error("reserved read bits not zero");
   cov_servo: cover property ($rose(axis_servo_on));
   cov_estop: cover property (axis_emerg_stop);
   cov_clutch: cover property ($rose(axis_clutch_engage));
   cov_irq: cover property ($rose(irq));
endmodule
bind acsf_top acsf_top_asserts #(.ADR_W(ADR_W)) u_chk (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .axis_servo_on,
   .axis_fault_clear, .axis_decel_stop, .axis_emerg_stop, .axis_clutch_engage,
   .axis_speed_run, .axis_torque_run);
`default_nettype wire

// file: dv/acsf_axis_model.sv
// servo drive stand-in: answers clutch and run requests after a settable delay
`timescale 1ns/1ns
`default_nettype none
module acsf_axis_model (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] dly,
   input wire logic engage,
   input wire logic speed_run,
   input wire logic torque_run,
   output logic engage_done,
   output logic release_done,
   output logic speed_reached,
   output logic torque_reached
);
   logic eng_q;
   logic [3:0] c_eng;
   logic [3:0] c_spd;
   logic [3:0] c_trq;
   // counts restart on every change, so a large dly models a slow drive
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         eng_q <= 1'b0;
         c_eng <= 4'h0;
         c_spd <= 4'h0;
         c_trq <= 4'h0;
      end else begin
         eng_q <= engage;
         c_eng <= (engage != eng_q) ? 4'h0 : c_eng + {3'h0, c_eng != 4'hF};
         c_spd <= speed_run ? c_spd + {3'h0, c_spd != 4'hF} : 4'h0;
         c_trq <= torque_run ? c_trq + {3'h0, c_trq != 4'hF} : 4'h0;
      end
   end
   // done levels only once the request has stood long enough
   assign engage_done = engage && eng_q && c_eng >= dly;
   assign release_done = !engage && !eng_q && c_eng >= dly;
   assign speed_reached = speed_run && c_spd >= dly;
   assign torque_reached = torque_run && c_trq >= dly;
endmodule
`default_nettype wire

// file: dv/tb_axis_command_status_flags.sv
// self-checking bench for the axis command and status flag block
`timescale 1ns/1ns
`default_nettype none
`include "acsf_map.vh"
module tb_axis_command_status_flags;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic [15:0] lv = 16'h0;
   logic [3:0] dly = 4'h2;
   logic [31:0] q;
   logic [31:0] bm;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, irq, axis_servo_on, axis_fault_clear, axis_decel_stop, axis_emerg_stop;
   wire axis_clutch_engage, axis_speed_run, axis_torque_run, eng_ok, rel_ok, spd_ok, trq_ok;
   integer n_mismatch = 0;
   integer n_compared = 0;
   integer n_fclr = 0;
   integer n_dst = 0;
   integer n_est = 0;
   integer i;
   int pos [0:9] = '{18, 19, 20, 21, 11, 12, 13, 9, 10, 16};
   always #20 sys_clk = ~sys_clk;
   // count command pulses so a doubled pulse shows up
   always @(posedge sys_clk) begin
      n_fclr <= n_fclr + axis_fault_clear;
      n_dst <= n_dst + axis_decel_stop;
      n_est <= n_est + axis_emerg_stop;
   end
   acsf_top dut (.sys_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .origin_pin(lv[0]), .positive_pin(lv[1]),
      .negative_pin(lv[2]), .index_pin(lv[3]), .start_limit_pin(lv[4]), .pos_limit_pin(lv[5]),
      .neg_limit_pin(lv[6]), .fwd_soft_limit(lv[7]), .rev_soft_limit(lv[8]),
      .sync_params_applied(lv[9]), .probe1_pin(lv[10]), .probe2_pin(lv[11]),
      .drive_fault(lv[12]), .tracking_error(lv[13]), .speed_at_limit(lv[14]),
      .torque_at_limit(lv[15]), .clutch_engage_done(eng_ok), .clutch_release_done(rel_ok),
      .speed_reached(spd_ok), .torque_reached(trq_ok), .axis_servo_on, .axis_fault_clear,
      .axis_decel_stop, .axis_emerg_stop, .axis_clutch_engage, .axis_speed_run,
      .axis_torque_run);
   acsf_axis_model u_axis (.sys_clk, .sys_rst, .dly, .engage(axis_clutch_engage),
      .speed_run(axis_speed_run), .torque_run(axis_torque_run), .engage_done(eng_ok),
      .release_done(rel_ok), .speed_reached(spd_ok), .torque_reached(trq_ok));
   task print_verdict;
      begin
         if (n_mismatch == 0 && n_compared > 0) begin
            $display("TEST PASSED");
         end else begin
            $display("TEST FAILED");
         end
         $finish;
      end
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge sys_clk);
   endtask
   // one classic cycle; request held until ack is sampled, then released
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge sys_clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_sel_i <= 4'hF;
         wb_adr_i <= a;
         wb_dat_i <= d;
         n = 0;
         @(posedge sys_clk);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         q = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
         wb_we_i <= 1'b0;
         if (n >= 20) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0t no bus answer", $time);
         end
      end
   endtask
   task wt(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      begin
         xfer(1'b0, a, 32'h0);
         chk(q & m, e);
      end
   endtask
   // watchdog: the tests need well under a thousand cycles
   initial begin
      #400000;
      n_mismatch = n_mismatch + 1;
      print_verdict;
   end
   initial begin
      tick(2);
      sys_rst <= 1'b0;
      rdc(`ACSF_CMD_OFS, 32'hFFFFFFFF, 32'h0);
      rdc(`ACSF_MODE_OFS, 32'hFFFFFFFF, 32'h0);
      rdc(`ACSF_MASK_OFS, 32'hFFFFFFFF, 32'h0);
      rdc(`ACSF_EVT_OFS, 32'hFFFFFFFF, 32'h0);
      wt(8'h14, 32'hFFFFFFFF);
      rdc(8'h14, 32'hFFFFFFFF, 32'h0);
      wt(`ACSF_CMD_OFS, 32'hFFFFFF80);
      rdc(`ACSF_CMD_OFS, 32'hFFFFFFFF, 32'h0);
      wt(`ACSF_CMD_OFS, 32'h1);
      tick(1);
      chk(axis_servo_on, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h1, 32'h1);
      wt(`ACSF_MODE_OFS, 32'h1);
      tick(2);
      chk(axis_speed_run, 32'h1);
      tick(8);
      rdc(`ACSF_STAT_OFS, 32'h60, 32'h60);
      wt(`ACSF_CMD_OFS, 32'h5);
      tick(2);
      chk(axis_speed_run, 32'h0);
      chk(n_dst, 32'h1);
      rdc(`ACSF_MODE_OFS, 32'h3, 32'h0);
      wt(`ACSF_CMD_OFS, 32'h1);
      wt(`ACSF_MODE_OFS, 32'h2);
      tick(10);
      chk(axis_torque_run, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h180, 32'h180);
      dly <= 4'hF;
      wt(`ACSF_MODE_OFS, 32'h1);
      tick(2);
      chk(axis_torque_run, 32'h0);
      rdc(`ACSF_STAT_OFS, 32'h40, 32'h0);
      lv[14] <= 1'b1;
      tick(4);
      rdc(`ACSF_STAT_OFS, 32'h40, 32'h40);
      lv[14] <= 1'b0;
      wt(`ACSF_CMD_OFS, 32'h9);
      tick(2);
      chk(axis_speed_run, 32'h0);
      chk(n_est, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h4, 32'h4);
      lv[12] <= 1'b1;
      tick(4);
      lv[12] <= 1'b0;
      rdc(`ACSF_STAT_OFS, 32'h2, 32'h2);
      wt(`ACSF_CMD_OFS, 32'h3);
      wt(`ACSF_CMD_OFS, 32'h3);
      tick(2);
      chk(n_fclr, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h6, 32'h0);
      dly <= 4'h4;
      wt(`ACSF_CMD_OFS, 32'h11);
      tick(1);
      chk(axis_clutch_engage, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h18, 32'h8);
      tick(12);
      rdc(`ACSF_STAT_OFS, 32'h18, 32'h10);
      wt(`ACSF_CMD_OFS, 32'h1);
      rdc(`ACSF_STAT_OFS, 32'h18, 32'h18);
      tick(12);
      rdc(`ACSF_STAT_OFS, 32'h18, 32'h0);
      for (i = 0; i < 10; i = i + 1) begin
         bm = 32'h1 << pos[i];
         lv[i] <= 1'b1;
         tick(4);
         rdc(`ACSF_STAT_OFS, bm, bm);
         lv[i] <= 1'b0;
         tick(4);
         rdc(`ACSF_STAT_OFS, bm, 32'h0);
      end
      wt(`ACSF_MODE_OFS, 32'hC);
      for (i = 0; i < 2; i = i + 1) begin
         bm = 32'h4000 << i;
         lv[10 + i] <= 1'b1;
         tick(4);
         lv[10 + i] <= 1'b0;
         rdc(`ACSF_STAT_OFS, bm, bm);
         wt(`ACSF_CMD_OFS, (32'h20 << i) | 32'h1);
         rdc(`ACSF_STAT_OFS, bm, 32'h0);
      end
      wt(`ACSF_MASK_OFS, 32'h4);
      lv[13] <= 1'b1;
      tick(4);
      lv[13] <= 1'b0;
      rdc(`ACSF_STAT_OFS, 32'h20000, 32'h20000);
      chk(irq, 32'h1);
      wt(`ACSF_CMD_OFS, 32'h43);
      rdc(`ACSF_STAT_OFS, 32'h20000, 32'h0);
      wt(`ACSF_EVT_OFS, 32'h4);
      tick(2);
      chk(irq, 32'h0);
      wt(`ACSF_MASK_OFS, 32'h0);
      lv[13] <= 1'b1;
      tick(4);
      lv[13] <= 1'b0;
      rdc(`ACSF_EVT_OFS, 32'h4, 32'h4);
      chk(irq, 32'h0);
      // slow drive, so only the torque limit input can finish the run
      dly <= 4'hF;
      wt(`ACSF_MODE_OFS, 32'h2);
      tick(2);
      rdc(`ACSF_STAT_OFS, 32'h180, 32'h80);
      lv[15] <= 1'b1;
      tick(4);
      lv[15] <= 1'b0;
      rdc(`ACSF_STAT_OFS, 32'h100, 32'h100);
      print_verdict;
   end
endmodule
`default_nettype wire
